// ---- core/ivl_pkg.sv ----
// Purpose: Constants and carriers for the input voltage limit registers
// Assumes: Command codes are eight bits, data words sixteen bits
// Notes: Thresholds are compared in quarter volts
package ivl_pkg;
    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CMD_TURN_ON = 8'h35;
    localparam logic [7:0] CMD_OV = 8'h55;
    localparam logic [7:0] CMD_UV = 8'h59;
    localparam logic [7:0] CMD_STATUS = 8'h7c;
    localparam logic [7:0] CMD_PHASE_SEL = 8'hd0;
    localparam logic [7:0] PAGE_A = 8'h00;
    localparam logic [7:0] PAGE_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    // ****************************************************************
    // Field layouts and limits
    // ****************************************************************
    localparam logic [4:0] TURN_ON_EXP = 5'h1e;
    localparam logic [4:0] OV_EXP = 5'h00;
    localparam logic [10:0] TURN_ON_MAN_MIN = 11'h01d;
    localparam logic [10:0] TURN_ON_MAN_MAX = 11'h02d;
    localparam logic [1:0] TURN_ON_MAN_LSB = 2'h1;
    localparam logic [10:0] OV_MAN_MAX = 11'h01f;
    localparam logic [15:0] UV_MIN = 16'hf80f;
    localparam logic [15:0] UV_MAX = 16'hf817;
    localparam int STAT_OV_BIT = 7;
    localparam int STAT_UV_BIT = 4;
    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [10:0] TURN_ON_MAN_RST = 11'h01d;
    localparam logic [10:0] OV_MAN_RST = 11'h00f;
    localparam logic [15:0] UV_RST = 16'hf80f;
    localparam logic [3:0] PHASE_RST = 4'h0;
    localparam logic [7:0] PAGE_RST = 8'h00;
    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic write;
        logic word;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } ivl_req_s;
    typedef struct packed {
        logic err;
        logic [15:0] rdata;
    } ivl_rsp_s;
endpackage : ivl_pkg

// ---- core/ivl_regs.sv ----
// Purpose: Input turn-on, overvoltage and undervoltage limit commands
// Assumes: Link requests arrive on i_lnk_clk, the core runs on i_clk
// Notes: One request in flight; toggle handshake in both directions
// Functional notes
// - Conversion is held off until the input reaches the turn-on level.
// - The turn-on command is a linear word and is taken by word only.
// - Turn-on and overvoltage limits ignore the page and serve both.
// - Turn-on exponent reads as minus two and cannot be written.
// - Turn-on mantissa is writable and loaded from non-volatile memory.
// - Only turn-on mantissas 01Dh to 02Dh in steps of four are taken, whatever the exponent bits.
// - Only undervoltage words F80Fh to F817h in steps of two are taken.
// - An overvoltage fault is flagged when the input exceeds the limit.
// - The overvoltage command is a linear word taken by word only.
// - Overvoltage exponent reads as zero and cannot be written.
// - Overvoltage mantissa is writable, valid from zero to 31.
// - On page zero the select field sets the channel A phase limit.
// - On page one the select field sets the channel B phase limit.
// - Undervoltage is masked until first turn-on with the unit enabled.
// - Overvoltage sets status and alerts but conversion carries on.
`timescale 1ns/1ps
module ivl_regs
    import ivl_pkg::*;
(
    // Core clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link clock and reset
    input wire logic i_lnk_clk,
    input wire logic i_lnk_rst,
    // Link request and answer
    input wire logic i_lnk_valid,
    input wire ivl_req_s i_lnk_req,
    output logic o_lnk_busy,
    output logic o_lnk_done,
    output ivl_rsp_s o_lnk_rsp,
    // Non-volatile defaults
    input wire logic i_nvm_load,
    input wire logic [10:0] i_nvm_turn_on_man,
    input wire logic [10:0] i_nvm_ov_man,
    // Measured input in quarter volts, and enable pin
    input wire logic [15:0] i_vin_q,
    input wire logic i_enable,
    // Power stage controls and status
    output logic o_convert_en,
    output logic o_ov_fault,
    output logic o_uv_fault,
    output logic o_alert,
    output logic [3:0] o_channel_a_phase_current_limit,
    output logic [3:0] o_channel_b_phase_current_limit
);
    // ****************************************************************
    // Link domain
    // ****************************************************************
    ivl_req_s lreq_r, lreq_nxt;
    ivl_rsp_s lrsp_r, lrsp_nxt;
    logic lbusy_r, lbusy_nxt, ldone_r, ldone_nxt;
    logic ltog_r, ltog_nxt, lseen_r, lseen_nxt;
    logic ack_s1_r, ack_s2_r, ack_s3_r;
    logic ack_tog_r;
    ivl_rsp_s rsp_r;

    always_comb begin
        lreq_nxt = lreq_r;
        lrsp_nxt = lrsp_r;
        lbusy_nxt = lbusy_r;
        ltog_nxt = ltog_r;
        lseen_nxt = lseen_r;
        ldone_nxt = 1'b0;
        if (i_lnk_valid && !lbusy_r) begin
            lreq_nxt = i_lnk_req;
            ltog_nxt = !ltog_r;
            lbusy_nxt = 1'b1;
        end else if (ack_s2_r == ack_s3_r && ack_s3_r != lseen_r) begin
            lseen_nxt = ack_s3_r;
            lrsp_nxt = rsp_r;
            lbusy_nxt = 1'b0;
            ldone_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_lnk_clk) begin
        if (i_lnk_rst) begin
            lreq_r <= '0;
            lrsp_r <= '0;
            lbusy_r <= 1'b0;
            ldone_r <= 1'b0;
            ltog_r <= 1'b0;
            lseen_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            lreq_r <= lreq_nxt;
            lrsp_r <= lrsp_nxt;
            lbusy_r <= lbusy_nxt;
            ldone_r <= ldone_nxt;
            ltog_r <= ltog_nxt;
            lseen_r <= lseen_nxt;
            ack_s1_r <= ack_tog_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    assign o_lnk_busy = lbusy_r;
    assign o_lnk_done = ldone_r;
    assign o_lnk_rsp = lrsp_r;

    // ****************************************************************
    // Core domain: synchronisers
    // ****************************************************************
    logic req_s1_r, req_s2_r, req_s3_r;
    logic en_s1_r, en_s2_r, en_s3_r, en_r, en_nxt;
    logic req_evt;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            en_s3_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            req_s1_r <= ltog_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            en_s1_r <= i_enable;
            en_s2_r <= en_s1_r;
            en_s3_r <= en_s2_r;
            en_r <= en_nxt;
        end
    end

    // Enable counts once the last two stages agree
    always_comb begin
        en_nxt = en_r;
        if (en_s2_r == en_s3_r) begin
            en_nxt = en_s3_r;
        end
    end

    // Request data held still by the link while busy
    assign req_evt = req_s2_r == req_s3_r && req_s3_r != ack_tog_r;

    // ****************************************************************
    // Core domain: command registers
    // ****************************************************************
    logic [10:0] on_man_r, on_man_nxt, ov_man_r, ov_man_nxt;
    logic [15:0] uv_r, uv_nxt;
    logic [7:0] page_r, page_nxt;
    logic [3:0] ocl_a_r, ocl_a_nxt, ocl_b_r, ocl_b_nxt;
    logic ack_nxt;
    ivl_rsp_s rsp_nxt;
    logic clear_req;
    logic on_ok, ov_ok, uv_ok, nvm_on_ok, nvm_ov_ok;
    ivl_req_s rq;

    assign rq = lreq_r;
    assign on_ok = rq.wdata[10:0] >= TURN_ON_MAN_MIN &&
        rq.wdata[10:0] <= TURN_ON_MAN_MAX &&
        rq.wdata[1:0] == TURN_ON_MAN_LSB;
    assign nvm_on_ok = i_nvm_turn_on_man >= TURN_ON_MAN_MIN &&
        i_nvm_turn_on_man <= TURN_ON_MAN_MAX &&
        i_nvm_turn_on_man[1:0] == TURN_ON_MAN_LSB;
    assign ov_ok = rq.wdata[10:0] <= OV_MAN_MAX;
    assign nvm_ov_ok = i_nvm_ov_man <= OV_MAN_MAX;
    assign uv_ok = rq.wdata >= UV_MIN && rq.wdata <= UV_MAX &&
        rq.wdata[0];

    always_comb begin
        on_man_nxt = on_man_r;
        ov_man_nxt = ov_man_r;
        uv_nxt = uv_r;
        page_nxt = page_r;
        ocl_a_nxt = ocl_a_r;
        ocl_b_nxt = ocl_b_r;
        ack_nxt = ack_tog_r;
        rsp_nxt = rsp_r;
        clear_req = 1'b0;
        if (i_nvm_load) begin
            if (nvm_on_ok) begin
                on_man_nxt = i_nvm_turn_on_man;
            end
            if (nvm_ov_ok) begin
                ov_man_nxt = i_nvm_ov_man;
            end
        end
        if (req_evt) begin
            ack_nxt = req_s3_r;
            rsp_nxt = '0;
            unique case (rq.cmd)
                CMD_PAGE: begin
                    rsp_nxt.rdata = {8'h00, page_r};
                    if (rq.word) begin
                        rsp_nxt.err = 1'b1;
                    end else if (rq.write) begin
                        if (rq.wdata[7:0] == PAGE_A ||
                            rq.wdata[7:0] == PAGE_B ||
                            rq.wdata[7:0] == PAGE_ALL) begin
                            page_nxt = rq.wdata[7:0];
                        end else begin
                            rsp_nxt.err = 1'b1;
                        end
                    end
                end
                CMD_CLEAR: begin
                    clear_req = rq.write;
                    rsp_nxt.err = !rq.write;
                end
                // Shared commands: page is not consulted
                CMD_TURN_ON: begin
                    rsp_nxt.rdata = {TURN_ON_EXP, on_man_r};
                    if (!rq.word) begin
                        rsp_nxt.err = 1'b1;
                    end else if (rq.write) begin
                        if (on_ok) begin
                            on_man_nxt = rq.wdata[10:0];
                        end else begin
                            rsp_nxt.err = 1'b1;
                        end
                    end
                end
                CMD_OV: begin
                    rsp_nxt.rdata = {OV_EXP, ov_man_r};
                    if (!rq.word) begin
                        rsp_nxt.err = 1'b1;
                    end else if (rq.write) begin
                        if (ov_ok) begin
                            ov_man_nxt = rq.wdata[10:0];
                        end else begin
                            rsp_nxt.err = 1'b1;
                        end
                    end
                end
                CMD_UV: begin
                    rsp_nxt.rdata = uv_r;
                    if (!rq.word) begin
                        rsp_nxt.err = 1'b1;
                    end else if (rq.write) begin
                        if (uv_ok) begin
                            uv_nxt = rq.wdata;
                        end else begin
                            rsp_nxt.err = 1'b1;
                        end
                    end
                end
                CMD_STATUS: begin
                    rsp_nxt.rdata = '0;
                    rsp_nxt.rdata[STAT_OV_BIT] = o_ov_fault;
                    rsp_nxt.rdata[STAT_UV_BIT] = o_uv_fault;
                    rsp_nxt.err = rq.write || rq.word;
                end
                CMD_PHASE_SEL: begin
                    rsp_nxt.rdata = {12'h000,
                        page_r == PAGE_B ? ocl_b_r : ocl_a_r};
                    if (rq.word) begin
                        rsp_nxt.err = 1'b1;
                    end else if (rq.write) begin
                        if (page_r != PAGE_B) begin
                            ocl_a_nxt = rq.wdata[3:0];
                        end
                        if (page_r != PAGE_A) begin
                            ocl_b_nxt = rq.wdata[3:0];
                        end
                    end
                end
                default: rsp_nxt.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            on_man_r <= TURN_ON_MAN_RST;
            ov_man_r <= OV_MAN_RST;
            uv_r <= UV_RST;
            page_r <= PAGE_RST;
            ocl_a_r <= PHASE_RST;
            ocl_b_r <= PHASE_RST;
            ack_tog_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            on_man_r <= on_man_nxt;
            ov_man_r <= ov_man_nxt;
            uv_r <= uv_nxt;
            page_r <= page_nxt;
            ocl_a_r <= ocl_a_nxt;
            ocl_b_r <= ocl_b_nxt;
            ack_tog_r <= ack_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign o_channel_a_phase_current_limit = ocl_a_r;
    assign o_channel_b_phase_current_limit = ocl_b_r;

    // ****************************************************************
    // Core domain: threshold checks and status
    // ****************************************************************
    logic signed [17:0] vin_s, on_s, ov_s, uv_s;
    logic vin_ge_on, ov_now, uv_now;
    logic conv_r, conv_nxt, armed_r, armed_nxt;
    logic ov_r, ov_nxt, uv_r2, uv_nxt2, alert_r, alert_nxt;

    // Quarter-volt scale: mantissa shifted by the fixed exponent
    assign vin_s = $signed({2'b00, i_vin_q});
    assign on_s = $signed({{7{on_man_r[10]}}, on_man_r});
    assign ov_s = $signed({{5{ov_man_r[10]}}, ov_man_r, 2'b00});
    assign uv_s = $signed({{6{uv_r[10]}}, uv_r[10:0], 1'b0});
    assign vin_ge_on = vin_s >= on_s;
    assign ov_now = vin_s > ov_s;
    assign uv_now = vin_s < uv_s;

    always_comb begin
        conv_nxt = en_r && vin_ge_on;
        armed_nxt = armed_r || (en_r && vin_ge_on);
        ov_nxt = ov_r;
        uv_nxt2 = uv_r2;
        if (clear_req) begin
            ov_nxt = 1'b0;
            uv_nxt2 = 1'b0;
        end
        if (ov_now) begin
            ov_nxt = 1'b1;
        end
        if (uv_now && armed_r) begin
            uv_nxt2 = 1'b1;
        end
        alert_nxt = ov_nxt || uv_nxt2;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            conv_r <= 1'b0;
            armed_r <= 1'b0;
            ov_r <= 1'b0;
            uv_r2 <= 1'b0;
            alert_r <= 1'b0;
        end else begin
            conv_r <= conv_nxt;
            armed_r <= armed_nxt;
            ov_r <= ov_nxt;
            uv_r2 <= uv_nxt2;
            alert_r <= alert_nxt;
        end
    end

    assign o_convert_en = conv_r;
    assign o_ov_fault = ov_r;
    assign o_uv_fault = uv_r2;
    assign o_alert = alert_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_word_req(logic [7:0] c, logic w);
        req_evt && rq.cmd == c && rq.word && rq.write == w;
    endsequence

    AST_HOLDOFF: assert property (!(en_r && vin_ge_on)
        |=> !o_convert_en)
        else $error("conversion began below turn-on level");
    AST_BYTE_REFUSED: assert property (req_evt &&
        rq.cmd == CMD_TURN_ON && !rq.word
        |=> rsp_r.err && $stable(on_man_r))
        else $error("byte access to turn-on taken");
    AST_ON_EXP: assert property (s_word_req(CMD_TURN_ON, 1'b0)
        |=> rsp_r.rdata[15:11] == TURN_ON_EXP)
        else $error("turn-on exponent wrong");
    AST_ON_SET: assert property (on_man_r[1:0] == TURN_ON_MAN_LSB &&
        on_man_r >= TURN_ON_MAN_MIN && on_man_r <= TURN_ON_MAN_MAX)
        else $error("turn-on mantissa outside accepted set");
    AST_UV_SET: assert property (uv_r >= UV_MIN && uv_r <= UV_MAX &&
        uv_r[0])
        else $error("undervoltage word outside accepted set");
    AST_OV_FLAG: assert property (ov_now |=> o_ov_fault && o_alert)
        else $error("overvoltage not flagged");
    AST_OV_EXP: assert property (s_word_req(CMD_OV, 1'b0)
        |=> rsp_r.rdata[15:11] == OV_EXP)
        else $error("overvoltage exponent wrong");
    AST_OV_RANGE: assert property (ov_man_r <= OV_MAN_MAX)
        else $error("overvoltage mantissa above 31");
    AST_PHASE_A: assert property (req_evt &&
        rq.cmd == CMD_PHASE_SEL && rq.write && !rq.word &&
        page_r == PAGE_A
        |=> ocl_a_r == $past(rq.wdata[3:0]) && $stable(ocl_b_r))
        else $error("channel A phase limit not set");
    AST_PHASE_B: assert property (req_evt &&
        rq.cmd == CMD_PHASE_SEL && rq.write && !rq.word &&
        page_r == PAGE_B
        |=> ocl_b_r == $past(rq.wdata[3:0]) && $stable(ocl_a_r))
        else $error("channel B phase limit not set");
    AST_UV_MASK: assert property (!armed_r && !o_uv_fault
        |=> !o_uv_fault)
        else $error("undervoltage raised before first turn-on");
    AST_OV_KEEPS_ON: assert property (o_ov_fault && en_r && vin_ge_on
        |=> o_convert_en)
        else $error("overvoltage stopped conversion");
    AST_LNK_DONE: assert property (@(posedge i_lnk_clk)
        disable iff (i_lnk_rst) o_lnk_done |-> !o_lnk_busy ##1 !o_lnk_done)
        else $error("link done not a single pulse");
endmodule : ivl_regs

// ---- testbench/ivl_host_model.sv ----
// Purpose: Host side of the link, issuing one command at a time
// Assumes: Link clock runs free while requests are made
// Notes: Released request lines show the inverse of the last request
`timescale 1ns/1ps
module ivl_host_model
    import ivl_pkg::*;
(
    // Link clock
    input wire logic i_lnk_clk,
    // Request towards the block
    output logic o_valid,
    output ivl_req_s o_req,
    // Answer from the block
    input wire logic i_busy,
    input wire logic i_done,
    input wire ivl_rsp_s i_rsp
);
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end

    // ****************************************************************
    // One transfer; answer is unknown if the block never responds
    // ****************************************************************
    task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                        input logic [15:0] d, output ivl_rsp_s r);
        int n;
        logic b;
        r = 'x;
        @(posedge i_lnk_clk);
        #1;
        o_valid = 1'b1;
        o_req = '{write: w, word: wd, cmd: c, wdata: d};
        n = 0;
        // Busy as it stands before the edge decides whether it is taken
        do begin
            b = i_busy;
            @(posedge i_lnk_clk);
            n++;
        end while (b && n < 20);
        #1;
        o_valid = 1'b0;
        o_req = ~o_req;
        // Busy must stand until the answer; an early drop leaves r unknown
        for (n = 0; n < 20; n++) begin
            @(posedge i_lnk_clk);
            #1;
            if (i_done === 1'b1) begin
                r = i_rsp;
                break;
            end
            if (i_busy !== 1'b1) begin
                break;
            end
        end
    endtask : xfer
endmodule : ivl_host_model

// ---- testbench/test_input_voltage_limit_regs.sv ----
// Purpose: Self-checking bench for the input voltage limit registers
// Assumes: Host model issues link commands; bench drives core inputs
// Notes: Turn-on levels are in quarter volts at the measured input
`timescale 1ns/1ps
module test_input_voltage_limit_regs;
    import ivl_pkg::*;
    logic i_clk, i_rst, i_lnk_clk, i_lnk_rst, i_nvm_load, i_enable;
    logic [10:0] i_nvm_turn_on_man, i_nvm_ov_man;
    logic [15:0] i_vin_q;
    logic lnk_valid, lnk_busy, lnk_done, o_convert_en, o_ov_fault;
    logic o_uv_fault, o_alert;
    logic [3:0] o_ch_a, o_ch_b;
    ivl_req_s lnk_req;
    ivl_rsp_s lnk_rsp, rsp;
    int n_fail = 0;
    int num_checks = 0;

    ivl_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_lnk_clk(i_lnk_clk),
        .i_lnk_rst(i_lnk_rst), .i_lnk_valid(lnk_valid), .i_lnk_req(lnk_req),
        .o_lnk_busy(lnk_busy), .o_lnk_done(lnk_done), .o_lnk_rsp(lnk_rsp),
        .i_nvm_load(i_nvm_load), .i_nvm_turn_on_man(i_nvm_turn_on_man),
        .i_nvm_ov_man(i_nvm_ov_man), .i_vin_q(i_vin_q), .i_enable(i_enable),
        .o_convert_en(o_convert_en), .o_ov_fault(o_ov_fault),
        .o_uv_fault(o_uv_fault), .o_alert(o_alert),
        .o_channel_a_phase_current_limit(o_ch_a),
        .o_channel_b_phase_current_limit(o_ch_b));
    ivl_host_model u_host (.i_lnk_clk(i_lnk_clk), .o_valid(lnk_valid),
        .o_req(lnk_req), .i_busy(lnk_busy), .i_done(lnk_done),
        .i_rsp(lnk_rsp));

    // ****************************************************************
    // Clocks, checks and closing
    // ****************************************************************
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        i_lnk_clk = 1'b0;
        #1.3;
        forever #3 i_lnk_clk = ~i_lnk_clk;
    end
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    task automatic x(input logic w, input logic wd, input logic [7:0] c,
                     input logic [15:0] d);
        u_host.xfer(w, wd, c, d, rsp);
        cyc(1);
    endtask : x

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(o_convert_en, 0);
        x(0, 1, CMD_TURN_ON, 16'h0);
        chk(rsp, {1'b0, 16'hf01d});
        x(0, 1, CMD_OV, 16'h0);
        chk(rsp, {1'b0, 16'h000f});
        i_nvm_turn_on_man = 11'h025;
        i_nvm_ov_man = 11'h014;
        i_nvm_load = 1'b1;
        cyc(1);
        i_nvm_load = 1'b0;
        x(0, 1, CMD_TURN_ON, 16'h0);
        chk(rsp, {1'b0, 16'hf025});
        x(0, 1, CMD_OV, 16'h0);
        chk(rsp, {1'b0, 16'h0014});
        i_nvm_turn_on_man = 11'h026;
        i_nvm_ov_man = 11'h020;
        i_nvm_load = 1'b1;
        cyc(1);
        i_nvm_load = 1'b0;
        x(0, 1, CMD_TURN_ON, 16'h0);
        chk(rsp, {1'b0, 16'hf025});
        x(0, 1, CMD_OV, 16'h0);
        chk(rsp, {1'b0, 16'h0014});
        i_enable = 1'b1;
        i_vin_q = 16'h0014;
        cyc(10);
        chk({o_uv_fault, o_convert_en}, 0);
    endtask : t_reset
    task automatic t_turn_on();
        for (int i = 0; i < 5; i++) begin
            x(1, 1, CMD_TURN_ON, 16'hf01d + 16'(4 * i));
            chk(rsp.err, 0);
            x(0, 1, CMD_TURN_ON, 16'h0);
            chk(rsp, {1'b0, 16'hf01d + 16'(4 * i)});
        end
        x(1, 1, CMD_TURN_ON, 16'hf01e);
        chk(rsp.err, 1);
        x(1, 1, CMD_TURN_ON, 16'h0021);
        x(0, 1, CMD_TURN_ON, 16'h0);
        chk(rsp, {1'b0, 16'hf021});
        x(0, 0, CMD_TURN_ON, 16'h0);
        chk(rsp.err, 1);
    endtask : t_turn_on
    task automatic t_ov_uv();
        x(1, 1, CMD_OV, 16'hf81f);
        x(0, 1, CMD_OV, 16'h0);
        chk(rsp, {1'b0, 16'h001f});
        x(1, 1, CMD_OV, 16'h0020);
        chk(rsp.err, 1);
        x(1, 0, CMD_OV, 16'h0005);
        chk(rsp.err, 1);
        x(1, 1, CMD_UV, 16'hf811);
        x(0, 1, CMD_UV, 16'h0);
        chk(rsp, {1'b0, 16'hf811});
        x(1, 1, CMD_UV, 16'hf810);
        chk(rsp.err, 1);
        x(1, 1, CMD_UV, 16'hf819);
        chk(rsp.err, 1);
        x(1, 1, CMD_UV, 16'hf80f);
    endtask : t_ov_uv
    task automatic t_page();
        x(1, 0, CMD_PAGE, {8'h00, PAGE_A});
        x(1, 0, CMD_PHASE_SEL, 16'h0005);
        x(1, 0, CMD_PAGE, {8'h00, PAGE_B});
        x(1, 0, CMD_PHASE_SEL, 16'h0009);
        x(1, 1, CMD_TURN_ON, 16'hf029);
        x(1, 1, CMD_OV, 16'h000b);
        cyc(4);
        chk({o_ch_a, o_ch_b}, 17'h59);
        x(1, 0, CMD_PAGE, {8'h00, PAGE_A});
        x(0, 1, CMD_TURN_ON, 16'h0);
        chk(rsp, {1'b0, 16'hf029});
        x(0, 1, CMD_OV, 16'h0);
        chk(rsp, {1'b0, 16'h000b});
        x(1, 0, CMD_PAGE, {8'h00, PAGE_ALL});
        x(1, 0, CMD_PHASE_SEL, 16'h000f);
        cyc(4);
        chk({o_ch_a, o_ch_b}, 17'hff);
        x(1, 0, CMD_PAGE, 16'h0002);
        chk(rsp.err, 1);
        x(1, 1, CMD_PHASE_SEL, 16'h0003);
        chk(rsp.err, 1);
        cyc(4);
        chk({o_ch_a, o_ch_b}, 17'hff);
    endtask : t_page
    task automatic t_power();
        i_vin_q = 16'd40;
        cyc(8);
        chk(o_convert_en, 0);
        i_vin_q = 16'd41;
        cyc(8);
        chk(o_convert_en, 1);
        i_vin_q = 16'd44;
        cyc(8);
        chk(o_ov_fault, 0);
        i_vin_q = 16'd45;
        cyc(8);
        chk({o_ov_fault, o_alert, o_convert_en}, 17'h7);
        x(0, 0, CMD_STATUS, 16'h0);
        chk(rsp.rdata[7], 1);
        i_vin_q = 16'd29;
        cyc(8);
        chk(o_uv_fault, 1);
        i_vin_q = 16'd41;
        x(1, 0, CMD_CLEAR, 16'h0);
        cyc(8);
        chk({o_ov_fault, o_uv_fault, o_alert}, 0);
    endtask : t_power

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        i_rst = 1'b1;
        i_lnk_rst = 1'b1;
        i_nvm_load = 1'b0;
        i_nvm_turn_on_man = 11'h01d;
        i_nvm_ov_man = 11'h00f;
        i_vin_q = 16'h0;
        i_enable = 1'b0;
        repeat (16) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        i_lnk_rst = 1'b0;
        cyc(4);
        t_reset();
        t_turn_on();
        t_ov_uv();
        t_page();
        t_power();
        conclude();
    end
    initial begin
        #60000;
        n_fail++;
        conclude();
    end
endmodule : test_input_voltage_limit_regs
